/* File: btx_pkg.sv */
// shared constants, types and decode for the branch, trap and extended arithmetic executor
package btx_pkg;

  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned INIT_MS = 20;
  localparam int unsigned INIT_CYCLES = (INIT_MS * CLK_HZ) / 1000;

  localparam logic [2:0] SP_IDX = 3'h6;
  localparam logic [2:0] PC_IDX = 3'h7;
  localparam logic [15:0] WORD_STEP = 16'h0002;

  localparam int FLAG_C = 0;
  localparam int FLAG_V = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_N = 3;
  localparam int CC_SET_BIT = 4;

  localparam logic [15:0] OPC_HALT = 16'h0000;
  localparam logic [15:0] OPC_WAIT = 16'h0001;
  localparam logic [15:0] OPC_RTI = 16'h0002;
  localparam logic [15:0] OPC_BPT = 16'h0003;
  localparam logic [15:0] OPC_IOT = 16'h0004;
  localparam logic [15:0] OPC_BUSRST = 16'h0005;
  localparam logic [15:0] OPC_RTT = 16'h0006;
  localparam logic [15:0] OPC_RTS = 16'h0080;
  localparam logic [15:0] MSK_RTS = 16'hfff8;
  localparam logic [15:0] OPC_CC = 16'h00a0;
  localparam logic [15:0] MSK_CC = 16'hffe0;
  localparam logic [15:0] OPC_JSR = 16'h0800;
  localparam logic [15:0] OPC_MUL = 16'h7000;
  localparam logic [15:0] OPC_DIV = 16'h7200;
  localparam logic [15:0] OPC_ASH = 16'h7400;
  localparam logic [15:0] OPC_ARITH_SHIFT_PAIR = 16'h7600;
  localparam logic [15:0] MSK_EIS = 16'hfe00;
  localparam logic [15:0] OPC_EMT = 16'h8800;
  localparam logic [15:0] OPC_TRAP = 16'h8900;
  localparam logic [15:0] MSK_TRAP = 16'hff00;
  localparam logic [7:0] BR_FIRST = 8'h83;
  localparam logic [7:0] BR_LAST = 8'h87;

  localparam logic [15:0] VEC_BPT = 16'h000c;
  localparam logic [15:0] VEC_IOT = 16'h0010;
  localparam logic [15:0] VEC_EMT = 16'h0018;
  localparam logic [15:0] VEC_TRAP = 16'h001c;

  typedef enum {
    OP_NONE, OP_HALT, OP_WAIT, OP_RTI, OP_RTT, OP_BPT, OP_IOT, OP_BUSRST, OP_RTS,
    OP_CC, OP_BR, OP_JSR, OP_EMT, OP_TRAP, OP_MUL, OP_DIV, OP_ASH, OP_ARITH_SHIFT_PAIR
  } btx_op_t;

  typedef enum {
    S_IDLE, S_PUSH_PS, S_PUSH_PC, S_VEC_PC, S_VEC_PS, S_POP_PC, S_POP_PS,
    S_JSR, S_RTS, S_HALT, S_WAIT, S_INIT
  } btx_state_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } btx_mem_req_t;

  typedef struct packed {
    logic ack;
    logic [15:0] rdata;
  } btx_mem_rsp_t;

  typedef struct packed {
    logic [15:0] hi;
    logic [15:0] lo;
    logic wr_hi;
    logic wr_lo;
    logic [3:0] nzvc;
  } btx_eis_res_t;

  function automatic btx_op_t decode(input logic [15:0] i);
    btx_op_t op;
    op = OP_NONE;
    if (i == OPC_HALT) op = OP_HALT;
    else if (i == OPC_WAIT) op = OP_WAIT;
    else if (i == OPC_RTI) op = OP_RTI;
    else if (i == OPC_RTT) op = OP_RTT;
    else if (i == OPC_BPT) op = OP_BPT;
    else if (i == OPC_IOT) op = OP_IOT;
    else if (i == OPC_BUSRST) op = OP_BUSRST;
    else if ((i & MSK_RTS) == OPC_RTS) op = OP_RTS;
    else if ((i & MSK_CC) == OPC_CC) op = OP_CC;
    else if ((i & MSK_EIS) == OPC_JSR) op = OP_JSR;
    else if ((i & MSK_EIS) == OPC_MUL) op = OP_MUL;
    else if ((i & MSK_EIS) == OPC_DIV) op = OP_DIV;
    else if ((i & MSK_EIS) == OPC_ASH) op = OP_ASH;
    else if ((i & MSK_EIS) == OPC_ARITH_SHIFT_PAIR) op = OP_ARITH_SHIFT_PAIR;
    else if ((i & MSK_TRAP) == OPC_EMT) op = OP_EMT;
    else if ((i & MSK_TRAP) == OPC_TRAP) op = OP_TRAP;
    else if (i[15:8] >= BR_FIRST && i[15:8] <= BR_LAST) op = OP_BR;
    return op;
  endfunction

endpackage

/* File: btx_eis.sv */
// extended arithmetic datapath: multiply, divide, single and combined shift
`timescale 1ns/1ps
`default_nettype none
module btx_eis (
  input var btx_pkg::btx_op_t op,
  input wire logic [15:0] a,
  input wire logic [15:0] b,
  input wire logic [15:0] opnd,
  input wire logic [3:0] nzvc_in,
  output btx_pkg::btx_eis_res_t res
);

  function automatic logic fits16(input logic [31:0] x);
    return (x[31:15] == 17'h00000) || (x[31:15] == 17'h1ffff);
  endfunction

  logic [31:0] prod;
  logic [31:0] dvd;
  logic [15:0] dsor;
  logic [31:0] quo;
  logic [31:0] rem;
  logic dz;
  logic arith_shift;
  logic [5:0] cnt;
  logic [6:0] rcnt;
  logic [31:0] v;
  logic [63:0] t;
  logic [63:0] s;
  logic [31:0] sres;
  logic sc;
  logic sv;

  assign prod = 32'($signed(a) * $signed(opnd));
  assign dvd = {a, b};
  assign dz = (opnd == 16'h0000);
  // substitute divisor keeps the divider defined; the result is discarded on zero
  assign dsor = dz ? 16'h0001 : opnd;
  assign quo = 32'($signed(dvd) / $signed({{16{dsor[15]}}, dsor}));
  assign rem = 32'($signed(dvd) % $signed({{16{dsor[15]}}, dsor}));
  assign arith_shift = (op == btx_pkg::OP_ASH);
  assign cnt = opnd[5:0];
  assign rcnt = 7'h40 - {1'b0, cnt};
  assign v = arith_shift ? {a, 16'h0000} : {a, b};
  assign t = {{32{v[31]}}, v};

  always_comb begin
    s = t;
    sres = v;
    sc = 1'b0;
    sv = 1'b0;
    if (cnt != 6'h00 && !cnt[5]) begin
      s = t << cnt;
      sres = s[31:0];
      sc = s[32];
      sv = (s[63:31] != {33{s[31]}});
    end else if (cnt[5]) begin
      s = 64'($signed(t) >>> (rcnt - 7'h01));
      sres = s[32:1];
      sc = arith_shift ? s[16] : s[0];
    end
  end

  always_comb begin
    res = '0;
    res.nzvc = nzvc_in;
    unique case (op)
      btx_pkg::OP_MUL: begin
        res.nzvc = {prod[31], prod == 32'h0, 1'b0, !fits16(prod)};
        res.hi = prod[31:16];
        res.lo = prod[15:0];
        res.wr_hi = 1'b1;
        res.wr_lo = 1'b1;
      end
      btx_pkg::OP_DIV: begin
        if (dz || !fits16(quo)) begin
          res.nzvc[btx_pkg::FLAG_V] = 1'b1;
          res.nzvc[btx_pkg::FLAG_C] = dz;
        end else begin
          res.nzvc = {quo[15], quo[15:0] == 16'h0, 1'b0, 1'b0};
          res.hi = quo[15:0];
          res.lo = rem[15:0];
          res.wr_hi = 1'b1;
          res.wr_lo = 1'b1;
        end
      end
      btx_pkg::OP_ASH, btx_pkg::OP_ARITH_SHIFT_PAIR: begin
        res.hi = sres[31:16];
        res.lo = sres[15:0];
        res.wr_hi = 1'b1;
        res.wr_lo = !arith_shift;
        res.nzvc = {sres[31], arith_shift ? sres[31:16] == 16'h0 : sres == 32'h0, sv, sc};
      end
      default: res.nzvc = nzvc_in;
    endcase
  end

endmodule
`default_nettype wire

/* File: btx_exec.sv */
// executor for branches, calls, traps, returns, flag operators and extended arithmetic
// What this block does
// - taken branch adds sign-extended doubled low byte to program counter
// - branch_lower_or_same branches when carry or zero is one
// - overflow clear branches on V zero; overflow set on V one
// - higher_or_same branches on carry zero; lower branches on carry one
// - call: stack down two, push link register, link gets counter, counter gets target
// - return: counter from register, register popped, stack up two
// - halt stops execution until console restarts it
// - wait releases bus until an interrupt request arrives
// - traps push status then counter, each after stack down two, then vector
// - io trap vectors through words 20 and 22 octal
// - breakpoint trap vectors through 14 and 16 octal
// - emulator trap range vectors through 30 and 32 octal
// - general trap range vectors through 34 and 36 octal
// - interrupt return pops counter then status; no-trace variant suppresses trace
// - bus reset drives init for twenty milliseconds, then continues
// - flag operators: bits 3..0 pick N Z V C, bit 4 sets or clears
// - multiply forms signed product; Z N from it, C if too wide, V cleared
// - multiply high half to register, low half to register or one
// - divide: C on zero divisor, V on zero or wide quotient
// - divide uses register pair dividend; quotient even, remainder odd
// - shift count is signed six bits; C gets last bit out
// - shift V on sign change; N and Z from result
// - combined shift works on the 32-bit register pair
// - divide overflow aborts with V set
`timescale 1ns/1ps
`default_nettype none
module btx_exec #(
  parameter int unsigned INIT_CYCLES = btx_pkg::INIT_CYCLES
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic instr_valid,
  input wire logic [15:0] instr,
  input wire logic [15:0] operand,
  output logic instr_ready,
  output logic instr_done,
  output logic illegal_op,
  output btx_pkg::btx_mem_req_t mem_o,
  input wire btx_pkg::btx_mem_rsp_t mem_i,
  output logic halted,
  input wire logic console_start,
  input wire logic reg_wr_en,
  input wire logic [2:0] reg_wr_sel,
  input wire logic [15:0] reg_wr_data,
  output logic bus_released,
  input wire logic irq_req,
  output logic bus_init,
  output logic trace_inhibit,
  output logic [7:0][15:0] regs_o,
  output logic [15:0] psw_o
);

  typedef struct packed {
    btx_pkg::btx_state_t st;
    logic [7:0][15:0] regs;
    logic [15:0] psw;
    logic [15:0] tmp;
    logic [15:0] vec;
    logic [31:0] cnt;
    logic [2:0] rsel;
    btx_pkg::btx_mem_req_t mem;
    logic done;
    logic illegal;
    logic notrace;
    logic inhibit;
    logic init;
  } btx_core_t;

  function automatic btx_pkg::btx_mem_req_t mem_rd(input logic [15:0] addr);
    return '{req: 1'b1, we: 1'b0, addr: addr, wdata: 16'h0000};
  endfunction

  function automatic btx_pkg::btx_mem_req_t mem_wr(input logic [15:0] addr, input logic [15:0] data);
    return '{req: 1'b1, we: 1'b1, addr: addr, wdata: data};
  endfunction

  function automatic logic br_taken(input logic [2:0] sel, input logic [15:0] p);
    unique case (sel)
      3'h3: br_taken = p[btx_pkg::FLAG_C] | p[btx_pkg::FLAG_Z];
      3'h4: br_taken = !p[btx_pkg::FLAG_V];
      3'h5: br_taken = p[btx_pkg::FLAG_V];
      3'h6: br_taken = !p[btx_pkg::FLAG_C];
      3'h7: br_taken = p[btx_pkg::FLAG_C];
      default: br_taken = 1'b0;
    endcase
  endfunction

  localparam logic [31:0] INIT_LAST = 32'(INIT_CYCLES - 1);

  btx_core_t q;
  btx_core_t d;
  btx_pkg::btx_op_t op;
  btx_pkg::btx_eis_res_t eis;
  logic [2:0] sr;
  logic accept;
  logic [15:0] sp;
  logic [15:0] disp;

  assign op = btx_pkg::decode(instr);
  assign sr = instr[8:6];
  assign sp = q.regs[btx_pkg::SP_IDX];
  assign disp = {{7{instr[7]}}, instr[7:0], 1'b0};
  assign accept = instr_valid && (q.st == btx_pkg::S_IDLE);

  btx_eis u_eis (
    .op(op),
    .a(q.regs[sr]),
    .b(q.regs[sr | 3'h1]),
    .opnd(operand),
    .nzvc_in(q.psw[3:0]),
    .res(eis)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    d = q;
    d.done = 1'b0;
    d.illegal = 1'b0;
    unique case (q.st)
      btx_pkg::S_IDLE: begin
        if (instr_valid) begin
          d.inhibit = 1'b0;
          d.done = 1'b1;
          unique case (op)
            btx_pkg::OP_BR: begin
              if (br_taken(instr[10:8], q.psw)) d.regs[btx_pkg::PC_IDX] = q.regs[btx_pkg::PC_IDX] + disp;
            end
            btx_pkg::OP_CC: begin
              if (instr[btx_pkg::CC_SET_BIT]) d.psw[3:0] = q.psw[3:0] | instr[3:0];
              else d.psw[3:0] = q.psw[3:0] & ~instr[3:0];
            end
            btx_pkg::OP_MUL, btx_pkg::OP_DIV, btx_pkg::OP_ASH, btx_pkg::OP_ARITH_SHIFT_PAIR: begin
              if (eis.wr_hi) d.regs[sr] = eis.hi;
              if (eis.wr_lo) d.regs[sr | 3'h1] = eis.lo;
              d.psw[3:0] = eis.nzvc;
            end
            btx_pkg::OP_HALT: begin
              d.done = 1'b0;
              d.st = btx_pkg::S_HALT;
            end
            btx_pkg::OP_WAIT: begin
              d.done = 1'b0;
              d.st = btx_pkg::S_WAIT;
            end
            btx_pkg::OP_BUSRST: begin
              d.done = 1'b0;
              d.init = 1'b1;
              d.cnt = 32'h0;
              d.st = btx_pkg::S_INIT;
            end
            btx_pkg::OP_BPT, btx_pkg::OP_IOT, btx_pkg::OP_EMT, btx_pkg::OP_TRAP: begin
              d.vec = (op == btx_pkg::OP_BPT) ? btx_pkg::VEC_BPT : (op == btx_pkg::OP_IOT) ? btx_pkg::VEC_IOT :
                (op == btx_pkg::OP_EMT) ? btx_pkg::VEC_EMT : btx_pkg::VEC_TRAP;
              d.regs[btx_pkg::SP_IDX] = sp - btx_pkg::WORD_STEP;
              d.mem = mem_wr(sp - btx_pkg::WORD_STEP, q.psw);
              d.done = 1'b0;
              d.st = btx_pkg::S_PUSH_PS;
            end
            btx_pkg::OP_RTI, btx_pkg::OP_RTT: begin
              d.notrace = (op == btx_pkg::OP_RTT);
              d.mem = mem_rd(sp);
              d.done = 1'b0;
              d.st = btx_pkg::S_POP_PC;
            end
            btx_pkg::OP_JSR: begin
              d.rsel = sr;
              d.tmp = operand;
              d.regs[btx_pkg::SP_IDX] = sp - btx_pkg::WORD_STEP;
              d.mem = mem_wr(sp - btx_pkg::WORD_STEP, q.regs[sr]);
              d.done = 1'b0;
              d.st = btx_pkg::S_JSR;
            end
            btx_pkg::OP_RTS: begin
              d.rsel = instr[2:0];
              d.regs[btx_pkg::PC_IDX] = q.regs[instr[2:0]];
              d.mem = mem_rd(sp);
              d.done = 1'b0;
              d.st = btx_pkg::S_RTS;
            end
            default: d.illegal = 1'b1;
          endcase
        end
      end
      btx_pkg::S_PUSH_PS: if (mem_i.ack) begin
        d.regs[btx_pkg::SP_IDX] = sp - btx_pkg::WORD_STEP;
        d.mem = mem_wr(sp - btx_pkg::WORD_STEP, q.regs[btx_pkg::PC_IDX]);
        d.st = btx_pkg::S_PUSH_PC;
      end
      btx_pkg::S_PUSH_PC: if (mem_i.ack) begin
        d.mem = mem_rd(q.vec);
        d.st = btx_pkg::S_VEC_PC;
      end
      btx_pkg::S_VEC_PC: if (mem_i.ack) begin
        d.tmp = mem_i.rdata;
        d.mem = mem_rd(q.vec + btx_pkg::WORD_STEP);
        d.st = btx_pkg::S_VEC_PS;
      end
      btx_pkg::S_VEC_PS: if (mem_i.ack) begin
        // new counter held back so counter and status load in the same cycle
        d.regs[btx_pkg::PC_IDX] = q.tmp;
        d.psw = mem_i.rdata;
        d.mem = '0;
        d.done = 1'b1;
        d.st = btx_pkg::S_IDLE;
      end
      btx_pkg::S_POP_PC: if (mem_i.ack) begin
        d.regs[btx_pkg::PC_IDX] = mem_i.rdata;
        d.regs[btx_pkg::SP_IDX] = sp + btx_pkg::WORD_STEP;
        d.mem = mem_rd(sp + btx_pkg::WORD_STEP);
        d.st = btx_pkg::S_POP_PS;
      end
      btx_pkg::S_POP_PS: if (mem_i.ack) begin
        d.psw = mem_i.rdata;
        d.regs[btx_pkg::SP_IDX] = sp + btx_pkg::WORD_STEP;
        d.inhibit = q.notrace;
        d.mem = '0;
        d.done = 1'b1;
        d.st = btx_pkg::S_IDLE;
      end
      btx_pkg::S_JSR: if (mem_i.ack) begin
        d.regs[q.rsel] = q.regs[btx_pkg::PC_IDX];
        d.regs[btx_pkg::PC_IDX] = q.tmp;
        d.mem = '0;
        d.done = 1'b1;
        d.st = btx_pkg::S_IDLE;
      end
      btx_pkg::S_RTS: if (mem_i.ack) begin
        d.regs[q.rsel] = mem_i.rdata;
        d.regs[btx_pkg::SP_IDX] = d.regs[btx_pkg::SP_IDX] + btx_pkg::WORD_STEP;
        d.mem = '0;
        d.done = 1'b1;
        d.st = btx_pkg::S_IDLE;
      end
      btx_pkg::S_HALT: begin
        if (reg_wr_en) d.regs[reg_wr_sel] = reg_wr_data;
        if (console_start) begin
          d.done = 1'b1;
          d.st = btx_pkg::S_IDLE;
        end
      end
      btx_pkg::S_WAIT: begin
        if (irq_req) begin
          d.done = 1'b1;
          d.st = btx_pkg::S_IDLE;
        end
      end
      btx_pkg::S_INIT: begin
        d.cnt = q.cnt + 32'h1;
        if (q.cnt == INIT_LAST) begin
          d.init = 1'b0;
          d.done = 1'b1;
          d.st = btx_pkg::S_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '{st: btx_pkg::S_IDLE, default: '0};
    end else begin
      q <= d;
    end
  end

  assign instr_ready = (q.st == btx_pkg::S_IDLE);
  assign instr_done = q.done;
  assign illegal_op = q.illegal;
  assign mem_o = q.mem;
  assign halted = (q.st == btx_pkg::S_HALT);
  assign bus_released = (q.st == btx_pkg::S_WAIT);
  assign bus_init = q.init;
  assign trace_inhibit = q.inhibit;
  assign regs_o = q.regs;
  assign psw_o = q.psw;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  property p_branch;
    @(posedge mclk) disable iff (!arst_n)
    accept && op == btx_pkg::OP_BR && br_taken(instr[10:8], q.psw)
      |=> q.regs[btx_pkg::PC_IDX] == $past(q.regs[btx_pkg::PC_IDX]) + $past(disp);
  endproperty
  a_branch: assert property (p_branch) else $error("taken branch target wrong");

  property p_branch_lower_or_same;
    @(posedge mclk) disable iff (!arst_n)
    accept && instr[15:8] == btx_pkg::BR_FIRST && !q.psw[btx_pkg::FLAG_C] && !q.psw[btx_pkg::FLAG_Z]
      |=> $stable(q.regs[btx_pkg::PC_IDX]);
  endproperty
  a_branch_lower_or_same: assert property (p_branch_lower_or_same) else $error("lower-or-same branched with C and Z clear");

  property p_cc;
    @(posedge mclk) disable iff (!arst_n)
    accept && op == btx_pkg::OP_CC |=>
      q.psw[3:0] == ($past(instr[4]) ? ($past(q.psw[3:0]) | $past(instr[3:0])) :
                     ($past(q.psw[3:0]) & ~$past(instr[3:0])));
  endproperty
  a_cc: assert property (p_cc) else $error("flag operator result wrong");

  sequence s_trap_push;
    q.st == btx_pkg::S_PUSH_PS && mem_o.we && mem_o.wdata == q.psw;
  endsequence
  property p_trap_order;
    @(posedge mclk) disable iff (!arst_n)
    accept && (op == btx_pkg::OP_IOT || op == btx_pkg::OP_BPT) |=>
      s_trap_push and (q.regs[btx_pkg::SP_IDX] == $past(sp) - btx_pkg::WORD_STEP);
  endproperty
  a_trap_order: assert property (p_trap_order) else $error("trap did not push status first");

  property p_vector;
    @(posedge mclk) disable iff (!arst_n)
    q.st == btx_pkg::S_VEC_PC |-> mem_o.req && !mem_o.we && mem_o.addr == q.vec &&
      (q.vec == btx_pkg::VEC_BPT || q.vec == btx_pkg::VEC_IOT || q.vec == btx_pkg::VEC_EMT ||
       q.vec == btx_pkg::VEC_TRAP);
  endproperty
  a_vector: assert property (p_vector) else $error("vector fetch address wrong");

  property p_iot_vec;
    @(posedge mclk) disable iff (!arst_n)
    accept && op == btx_pkg::OP_IOT |=> q.vec == btx_pkg::VEC_IOT;
  endproperty
  a_iot_vec: assert property (p_iot_vec) else $error("io trap vector not selected");

  property p_pop;
    @(posedge mclk) disable iff (!arst_n)
    q.st == btx_pkg::S_POP_PC && mem_i.ack |=>
      q.regs[btx_pkg::PC_IDX] == $past(mem_i.rdata) && sp == $past(sp) + btx_pkg::WORD_STEP;
  endproperty
  a_pop: assert property (p_pop) else $error("interrupt return pop wrong");

  property p_jsr;
    @(posedge mclk) disable iff (!arst_n)
    q.st == btx_pkg::S_JSR && mem_i.ack |=> q.regs[btx_pkg::PC_IDX] == $past(q.tmp) && instr_done;
  endproperty
  a_jsr: assert property (p_jsr) else $error("call did not load target");

  property p_halt;
    @(posedge mclk) disable iff (!arst_n)
    halted && !console_start |=> halted && !instr_ready;
  endproperty
  a_halt: assert property (p_halt) else $error("left halt without console");

  property p_wait;
    @(posedge mclk) disable iff (!arst_n)
    accept && op == btx_pkg::OP_WAIT ##1 !irq_req |-> bus_released && !mem_o.req;
  endproperty
  a_wait: assert property (p_wait) else $error("wait did not release bus");

  property p_init;
    @(posedge mclk) disable iff (!arst_n)
    $fell(bus_init) |-> $past(q.cnt) == INIT_LAST && instr_done;
  endproperty
  a_init: assert property (p_init) else $error("init pulse length wrong");

  property p_mul;
    @(posedge mclk) disable iff (!arst_n)
    accept && op == btx_pkg::OP_MUL |=> !q.psw[btx_pkg::FLAG_V] ##1 instr_ready;
  endproperty
  a_mul: assert property (p_mul) else $error("multiply left overflow set");

endmodule
`default_nettype wire

/* File: btx_mem_model.sv */
// memory partner: word store that answers each request after a chosen lag
`timescale 1ns/1ps
`default_nettype none
module btx_mem_model (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [1:0] lag,
  input wire btx_pkg::btx_mem_req_t req_i,
  output var btx_pkg::btx_mem_rsp_t rsp_o
);
  logic [15:0] ram [0:255];
  logic [1:0] cnt;
  ////////////////////////////////////////////////////////////////////////////////
  // read data flips every cycle outside an ack so a stale value never looks valid
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 2'h0;
      rsp_o <= '0;
    end else if (req_i.req && !rsp_o.ack && cnt >= lag) begin
      rsp_o.ack <= 1'h1;
      cnt <= 2'h0;
      if (req_i.we) begin
        ram[req_i.addr[8:1]] <= req_i.wdata;
        rsp_o.rdata <= ~rsp_o.rdata;
      end else begin
        rsp_o.rdata <= ram[req_i.addr[8:1]];
      end
    end else begin
      rsp_o.ack <= 1'h0;
      rsp_o.rdata <= ~rsp_o.rdata;
      if (req_i.req && !rsp_o.ack) begin
        cnt <= cnt + 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: branch_trap_ext_arith_exec_test.sv */
// self-checking bench for the branch, trap and extended arithmetic executor
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; $display("BAD %0t %h %h", $time, a, b); end end
module branch_trap_ext_arith_exec_test;
  logic mclk = 1'h0, arst_n = 1'h0, instr_valid = 1'h0, console_start = 1'h0, reg_wr_en = 1'h0, irq_req = 1'h0;
  logic [15:0] instr = 16'h0, operand = 16'h0, reg_wr_data = 16'h0, ps, t16, op16;
  logic [2:0] reg_wr_sel = 3'h0;
  logic [1:0] lag = 2'h0;
  logic instr_ready, instr_done, illegal_op, halted, bus_released, bus_init, trace_inhibit;
  logic [7:0][15:0] regs_o;
  logic [15:0] psw_o;
  logic [15:0] r [0:7];
  logic [31:0] seed = 32'h9145119a;
  logic [35:0] sh;
  btx_pkg::btx_mem_req_t mem_o;
  btx_pkg::btx_mem_rsp_t mem_i;
  int err_total = 0, cmp_count = 0, n, k, f;
  longint dv, ds, q;
  always #50 mclk = ~mclk;
  // short init count keeps the bus reset run brief
  btx_exec #(.INIT_CYCLES(8)) dut (.mclk(mclk), .arst_n(arst_n), .instr_valid(instr_valid), .instr(instr),
    .operand(operand), .instr_ready(instr_ready), .instr_done(instr_done), .illegal_op(illegal_op), .mem_o(mem_o),
    .mem_i(mem_i), .halted(halted), .console_start(console_start), .reg_wr_en(reg_wr_en), .reg_wr_sel(reg_wr_sel),
    .reg_wr_data(reg_wr_data), .bus_released(bus_released), .irq_req(irq_req), .bus_init(bus_init),
    .trace_inhibit(trace_inhibit), .regs_o(regs_o), .psw_o(psw_o));
  btx_mem_model mem (.mclk(mclk), .arst_n(arst_n), .lag(lag), .req_i(mem_o), .rsp_o(mem_i));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[15:0];
  endfunction
  // shift reference: single shifts ride in the upper half of the word
  function automatic logic [35:0] shx(input logic [31:0] v, input logic pair, input logic [5:0] c);
    logic [95:0] t;
    logic [31:0] h;
    t = {{64{v[31]}}, v} << (c + 6'h20);
    h = t[63:32];
    return {h[31], pair ? h == 0 : h[31:16] == 0, h[31] ? t[95:64] != '1 : t[95:64] != 0,
      c == 0 ? 1'h0 : c[5] ? (pair ? t[31] : t[47]) : t[64], h};
  endfunction
  task end_sim;
    if (err_total == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task send(input logic [15:0] i, input logic [15:0] o);
    @(posedge mclk);
    instr_valid <= 1'h1;
    instr <= i;
    operand <= o;
    @(posedge mclk);
    instr_valid <= 1'h0;
  endtask
  task finish;
    int w;
    for (w = 0; w < 500; w++) begin
      #1;
      if (instr_done === 1'h1 || illegal_op === 1'h1) break;
      @(posedge mclk);
    end
    if (w == 500) begin
      err_total++;
      end_sim;
    end
  endtask
  task issue(input logic [15:0] i, input logic [15:0] o);
    send(i, o);
    finish;
  endtask
  task check_all;
    int j;
    for (j = 0; j < 8; j++) `CHK(regs_o[j], r[j])
    `CHK(psw_o, ps)
  endtask
  task deposit(input logic [2:0] s, input logic [15:0] v);
    send(16'h0000, 16'h0);
    @(posedge mclk);
    reg_wr_en <= 1'h1;
    reg_wr_sel <= s;
    reg_wr_data <= v;
    #1 `CHK(halted, 1'h1)
    `CHK(instr_ready, 1'h0)
    @(posedge mclk);
    reg_wr_en <= 1'h0;
    console_start <= 1'h1;
    finish;
    console_start <= 1'h0;
    r[s] = v;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    // vector status words keep the trace bit clear
    for (k = 0; k < 256; k++) mem.ram[k] = rnd() & 16'hffef;
    for (k = 0; k < 8; k++) r[k] = 16'h0;
    ps = 16'h0;
    repeat (12) @(posedge mclk);
    arst_n <= 1'h1;
    for (k = 0; k < 8; k++) deposit(k[2:0], k == 6 ? 16'h0180 : rnd() & 16'hfffe);
    check_all;
    for (k = 0; k < 32; k++) begin
      issue(btx_pkg::OPC_CC | k[15:0], 16'h0);
      ps[3:0] = k[4] ? ps[3:0] | k[3:0] : ps[3:0] & ~k[3:0];
      check_all;
    end
    for (k = 0; k < 5; k++) for (f = 0; f < 16; f++) begin
      issue(16'h00af, 16'h0);
      issue(16'h00b0 | f[15:0], 16'h0);
      ps[3:0] = f[3:0];
      t16 = rnd();
      issue({8'h83 + k[7:0], t16[7:0]}, 16'h0);
      if (k == 0 ? f[0] | f[2] : k == 1 ? !f[1] : k == 2 ? f[1] : k == 3 ? !f[0] : f[0])
        r[7] = r[7] + {{7{t16[7]}}, t16[7:0], 1'h0};
      check_all;
    end
    for (n = 0; n < 48; n++) begin
      t16 = rnd();
      op16 = n % 5 == 0 ? 16'h0 : rnd();
      f = t16[8:6] % 6;
      if (n % 2) f = f & 6;
      issue({7'h38 + 7'(n % 4), f[2:0], t16[5:0]}, op16);
      dv = $signed({r[f], r[f | 1]});
      ds = $signed(op16);
      case (n % 4)
        0: begin
          q = longint'($signed(r[f])) * ds;
          r[f] = q[31:16];
          r[f | 1] = q[15:0];
          ps[3:0] = {q[31], q == 0, 1'h0, q > 32767 || q < -32768};
        end
        1: if (ds == 0) ps[1:0] = 2'h3;
        else begin
          q = dv / ds;
          ds = dv % ds;
          if (q > 32767 || q < -32768) ps[1:0] = 2'h2;
          else begin
            r[f] = q[15:0];
            r[f | 1] = ds[15:0];
            ps[3:0] = {q[15], q[15:0] == 0, 2'h0};
          end
        end
        2: begin
          sh = shx({r[f], 16'h0}, 1'h0, op16[5:0]);
          r[f] = sh[31:16];
          ps[3:0] = sh[35:32];
        end
        default: begin
          sh = shx({r[f], r[f | 1]}, 1'h1, op16[5:0]);
          r[f] = sh[31:16];
          r[f | 1] = sh[15:0];
          ps[3:0] = sh[35:32];
        end
      endcase
      check_all;
    end
    for (k = 0; k < 8; k++) begin
      lag = 2'(rnd());
      t16 = rnd();
      op16 = k[1] ? (k[0] ? btx_pkg::OPC_TRAP : btx_pkg::OPC_EMT) : (k[0] ? btx_pkg::OPC_IOT : btx_pkg::OPC_BPT);
      n = k[1] ? (k[0] ? 14 : 12) : (k[0] ? 8 : 6);
      issue(op16 | {8'h0, t16[7:0] & {8{k[1]}}}, 16'h0);
      `CHK(mem.ram[(r[6] - 16'h2) >> 1], ps)
      `CHK(mem.ram[(r[6] - 16'h4) >> 1], r[7])
      t16 = r[7];
      op16 = ps;
      r[6] = r[6] - 16'h4;
      r[7] = mem.ram[n];
      ps = mem.ram[n + 1];
      check_all;
      issue(k[2] ? btx_pkg::OPC_RTT : btx_pkg::OPC_RTI, 16'h0);
      r[7] = t16;
      ps = op16;
      r[6] = r[6] + 16'h4;
      check_all;
      `CHK(trace_inhibit, k[2])
    end
    t16 = rnd() & 16'hfffe;
    issue(16'h0940, t16);
    `CHK(mem.ram[(r[6] - 16'h2) >> 1], r[5])
    r[6] = r[6] - 16'h2;
    r[5] = r[7];
    r[7] = t16;
    check_all;
    issue(16'h0085, 16'h0);
    r[7] = r[5];
    r[5] = mem.ram[r[6] >> 1];
    r[6] = r[6] + 16'h2;
    check_all;
    issue(16'h8200, 16'h0);
    `CHK(illegal_op, 1'h1)
    check_all;
    send(16'h0001, 16'h0);
    repeat (3) @(posedge mclk);
    #1 `CHK(bus_released, 1'h1)
    @(posedge mclk);
    irq_req <= 1'h1;
    finish;
    irq_req <= 1'h0;
    `CHK(bus_released, 1'h0)
    send(16'h0005, 16'h0);
    #1 n = bus_init;
    for (k = 0; k < 100; k++) begin
      @(posedge mclk);
      #1;
      if (instr_done === 1'h1) break;
      n += bus_init;
    end
    if (k == 100) err_total++;
    `CHK(n, 8)
    `CHK(bus_init, 1'h0)
    end_sim;
  end
endmodule
`default_nettype wire
